// ===== verilog/wid_decoder.v
// Decode stage of a 16-bit memory-workspace processor with its context registers.
// Assumes a same-clock memory port that answers each held request with a one-cycle ack,
// and an AHB-Lite master with this block as its only slave.
//
// Functional notes
// - Context swap saves only base, counter, flags.
// - Sixteen registers start at loadable base pointer.
// - Shift and immediate operands are workspace registers.
// - Instructions are one to three words.
// - Nine layouts recognised, fields extracted per layout.
// - Byte indicator one means byte operand.
// - Mode codes: direct, indirect, memory, autoincrement.
// - Memory mode register zero means not indexed.
// - Register fields name registers 0 to 15.
// - Relative target is counter plus twice the displacement.
// - Count field gives shift or serial bits.
// - Byte direct register access uses high byte.
// - Operation code 110 decodes as move.
// - Destination fields high, source fields low.
// - Indirect reads register, contents become address.
// - Serial transfers up to eight bits set parity.
// - Execute instruction itself changes no flags.
// - Extended operation start sets its flag.
// - Autoincrement adds one byte or two word.
// - Memory mode uses next word, plus index.
`timescale 1ns/1ps
`include "wid_defs.vh"

module wid_decoder (
   input  wire        mclk_i,
   input  wire        rst_i,
   input  wire        hsel_i,
   input  wire [7:0]  haddr_i,
   input  wire [1:0]  htrans_i,
   input  wire        hwrite_i,
   input  wire [2:0]  hsize_i,
   input  wire [31:0] hwdata_i,
   input  wire        hready_i,
   output reg  [31:0] hrdata_o,
   output reg         hreadyout_o,
   output reg         hresp_o,
   output reg         mem_req_o,
   output reg         mem_we_o,
   output reg  [15:0] mem_addr_o,
   output reg  [15:0] mem_wdata_o,
   input  wire [15:0] mem_rdata_i,
   input  wire        mem_ack_i
);

   // ********************************************************************
   // States.
   // ********************************************************************
   localparam [9:0] S_IDLE  = 10'h001;
   localparam [9:0] S_FETCH = 10'h002;
   localparam [9:0] S_DEC   = 10'h004;
   localparam [9:0] S_OPND  = 10'h008;
   localparam [9:0] S_REGRD = 10'h010;
   localparam [9:0] S_INCWR = 10'h020;
   localparam [9:0] S_EXTRD = 10'h040;
   localparam [9:0] S_IDXRD = 10'h080;
   localparam [9:0] S_IMMRD = 10'h100;
   localparam [9:0] S_DATRD = 10'h200;

   reg  [9:0]  state;
   reg  [15:0] iw;
   reg  [15:0] wsp;
   reg  [15:0] pc;
   reg  [15:0] flag_word;
   reg  [15:0] src_ea;
   reg  [15:0] dst_ea;
   reg  [15:0] imm;
   reg  [15:0] target;
   reg  [15:0] ext;
   reg  [15:0] hold;
   reg  [15:0] sv_wsp;
   reg  [15:0] sv_pc;
   reg  [15:0] sv_flag;
   reg         opnd_dst;
   reg  [1:0]  cur_mode;
   reg  [3:0]  cur_reg;
   reg         done_flag;
   reg         ahb_wr;
   reg         ahb_rd;
   reg  [7:0]  ahb_addr;
   reg  [15:0] acc_addr;
   reg         acc_we;
   reg         acc_mem;
   reg  [31:0] rd_mux;

   // ********************************************************************
   // Instruction layout decode.
   // ********************************************************************
   wire        grp0   = (iw[15:12] == 4'h0);
   wire        grp3   = (iw[15:13] == 3'h1);
   wire        fmt1   = (iw[15:14] != 2'h0);
   wire        fmt2   = (iw[15:12] == 4'h1);
   wire        fmt3   = grp3 && ((iw[12:11] == 2'h0) || (iw[12:10] == 3'h2));
   wire        fmt4   = grp3 && (iw[12:11] == 2'h2);
   wire        fmt9   = grp3 && ((iw[12:10] == 3'h3) || (iw[12:11] == 2'h3));
   wire        fmt5   = grp0 && iw[11];
   wire        fmt6   = grp0 && (iw[11:10] == 2'h1);
   wire        ctl_sp = grp0 && (iw[11:9] == 3'h1) && iw[8] && (iw[7:5] != 3'h0);
   wire        fmt7   = ctl_sp;
   wire        fmt8   = grp0 && (iw[11:9] == 3'h1) && !ctl_sp;
   wire [8:0]  fmt_vec = {fmt9, fmt8, fmt7, fmt6, fmt5, fmt4, fmt3, fmt2, fmt1};

   // Destination fields sit in the upper half, source fields in the lower half.
   wire [1:0]  dest_mode_field   = iw[11:10];
   wire [3:0]  dest_reg_field    = iw[9:6];
   wire [1:0]  source_mode_field = iw[5:4];
   wire [3:0]  source_reg_field  = iw[3:0];
   wire        byte_ind          = fmt1 && iw[12];
   wire [3:0]  count_field       = fmt5 ? iw[7:4] : iw[9:6];
   wire [7:0]  disp_field        = iw[7:0];
   wire        is_move           = fmt1 && (iw[15:13] == `WID_OP_MOVE);
   wire        is_xop            = grp3 && (iw[12:10] == 3'h3);
   wire        is_exec           = fmt6 && (iw[9:6] == 4'h2);
   wire        serial_byte       = fmt4 && (count_field != 4'h0) &&
                                   (count_field <= `WID_SERIAL_MAX);
   wire        opnd_byte         = byte_ind || serial_byte;
   wire        imm_needed        = fmt8 && (iw[8:5] != 4'h5) && (iw[8:5] != 4'h6);

   // Shift and immediate layouts always name a workspace register directly.
   wire        has_src  = fmt1 || fmt3 || fmt4 || fmt5 || fmt6 || fmt8 || fmt9;
   wire        has_dst  = fmt1 || fmt3 || (fmt9 && !is_xop);
   wire [1:0]  src_mode = (fmt5 || fmt8) ? `WID_MODE_DIRECT : source_mode_field;
   wire [1:0]  dst_mode = fmt1 ? dest_mode_field : `WID_MODE_DIRECT;
   wire [15:0] step     = opnd_byte ? `WID_BYTE_STEP : `WID_WORD_STEP;
   wire [15:0] reg_addr = wsp + {11'h000, cur_reg, 1'b0};
   wire [15:0] rel_tgt  = pc + {{7{disp_field[7]}}, disp_field, 1'b0};
   wire [31:0] fields   = {6'h00, is_move, disp_field, count_field, byte_ind,
                           dest_mode_field, dest_reg_field, source_mode_field, source_reg_field};

   // ********************************************************************
   // Memory access address per state.
   // ********************************************************************
   always @* begin
      acc_addr = pc;
      acc_we   = 1'b0;
      acc_mem  = 1'b1;
      case (state)
         S_FETCH: acc_addr = pc;
         S_REGRD: acc_addr = reg_addr;
         S_INCWR: begin
            acc_addr = reg_addr;
            acc_we   = 1'b1;
         end
         S_EXTRD: acc_addr = pc;
         S_IDXRD: acc_addr = reg_addr;
         S_IMMRD: acc_addr = pc;
         S_DATRD: acc_addr = {src_ea[15:1], 1'b0};
         default: acc_mem  = 1'b0;
      endcase
   end

   // ********************************************************************
   // Register read mux.
   // ********************************************************************
   always @* begin
      rd_mux = 32'h0000_0000;
      case (ahb_addr)
         `WID_OFS_CTRL:    rd_mux = {30'h0000_0000, done_flag, (state != S_IDLE)};
         `WID_OFS_WSP:     rd_mux = {16'h0000, wsp};
         `WID_OFS_PC:      rd_mux = {16'h0000, pc};
         `WID_OFS_FLAG:    rd_mux = {16'h0000, flag_word};
         `WID_OFS_INSTR:   rd_mux = {16'h0000, iw};
         `WID_OFS_FORMAT:  rd_mux = {23'h00_0000, fmt_vec};
         `WID_OFS_FIELDS:  rd_mux = fields;
         `WID_OFS_SRC_EA:  rd_mux = {16'h0000, src_ea};
         `WID_OFS_DST_EA:  rd_mux = {16'h0000, dst_ea};
         `WID_OFS_TARGET:  rd_mux = {16'h0000, target};
         `WID_OFS_IMM:     rd_mux = {16'h0000, imm};
         `WID_OFS_SV_WSP:  rd_mux = {16'h0000, sv_wsp};
         `WID_OFS_SV_PC:   rd_mux = {16'h0000, sv_pc};
         `WID_OFS_SV_FLAG: rd_mux = {16'h0000, sv_flag};
         default:          rd_mux = 32'h0000_0000;
      endcase
   end

   // ********************************************************************
   // Operand completion: store the address, then go to the next operand.
   // ********************************************************************
   task finish_op;
      input [15:0] ea;
      begin
         if (!opnd_dst)
            src_ea <= ea;
         else
            dst_ea <= ea;
         if (!opnd_dst && has_dst) begin
            opnd_dst <= 1'b1;
            cur_mode <= dst_mode;
            cur_reg  <= dest_reg_field;
            state    <= S_OPND;
         end else if (imm_needed) begin
            state <= S_IMMRD;
         end else if (serial_byte) begin
            state <= S_DATRD;
         end else begin
            // Only the extended operation touches a flag here; the execute
            // instruction and all others leave the flag word as it was.
            if (is_xop && !is_exec)
               flag_word[`WID_FLAG_EXT_OP] <= 1'b1;
            done_flag <= 1'b1;
            state     <= S_IDLE;
         end
      end
   endtask

   // ********************************************************************
   // Bus slave, context registers and decode sequencer.
   // ********************************************************************
   always @(posedge mclk_i) begin
      if (rst_i) begin
         hrdata_o    <= 32'h0000_0000;
         hreadyout_o <= 1'b1;
         hresp_o     <= 1'b0;
         mem_req_o   <= 1'b0;
         mem_we_o    <= 1'b0;
         mem_addr_o  <= 16'h0000;
         mem_wdata_o <= 16'h0000;
         state       <= S_IDLE;
         iw          <= 16'h0000;
         wsp         <= `WID_WSP_RESET;
         pc          <= `WID_PC_RESET;
         flag_word   <= `WID_FLAG_RESET;
         src_ea      <= 16'h0000;
         dst_ea      <= 16'h0000;
         imm         <= 16'h0000;
         target      <= 16'h0000;
         ext         <= 16'h0000;
         hold        <= 16'h0000;
         sv_wsp      <= `WID_WSP_RESET;
         sv_pc       <= `WID_PC_RESET;
         sv_flag     <= `WID_FLAG_RESET;
         opnd_dst    <= 1'b0;
         cur_mode    <= `WID_MODE_DIRECT;
         cur_reg     <= 4'h0;
         done_flag   <= 1'b0;
         ahb_wr      <= 1'b0;
         ahb_rd      <= 1'b0;
         ahb_addr    <= 8'h00;
      end else begin
         // Reads take one wait state so that a read right behind a write sees it.
         hreadyout_o <= 1'b1;
         ahb_wr      <= 1'b0;
         ahb_rd      <= 1'b0;
         if (hsel_i && htrans_i[1] && hready_i) begin
            ahb_addr <= {haddr_i[7:2], 2'h0};
            ahb_wr   <= hwrite_i;
            ahb_rd   <= !hwrite_i;
            if (!hwrite_i)
               hreadyout_o <= 1'b0;
         end
         if (ahb_rd)
            hrdata_o <= rd_mux;

         // Software writes to the context are taken only while idle.
         if (ahb_wr && (state == S_IDLE)) begin
            case (ahb_addr)
               `WID_OFS_CTRL: begin
                  if (hwdata_i[`WID_CTRL_SAVE]) begin
                     sv_wsp  <= wsp;
                     sv_pc   <= pc;
                     sv_flag <= flag_word;
                  end
                  if (hwdata_i[`WID_CTRL_RESTORE]) begin
                     wsp       <= sv_wsp;
                     pc        <= sv_pc;
                     flag_word <= sv_flag;
                  end
                  if (hwdata_i[`WID_CTRL_START]) begin
                     done_flag <= 1'b0;
                     state     <= S_FETCH;
                  end
               end
               `WID_OFS_WSP:  wsp       <= hwdata_i[15:0];
               `WID_OFS_PC:   pc        <= hwdata_i[15:0];
               `WID_OFS_FLAG: flag_word <= hwdata_i[15:0];
               default: begin
               end
            endcase
         end

         if (acc_mem && !mem_req_o) begin
            mem_req_o   <= 1'b1;
            mem_we_o    <= acc_we;
            mem_addr_o  <= acc_addr;
            mem_wdata_o <= hold + step;
         end

         case (state)
            S_IDLE: begin
            end
            S_FETCH: begin
               if (mem_req_o && mem_ack_i) begin
                  mem_req_o <= 1'b0;
                  iw        <= mem_rdata_i;
                  pc        <= pc + `WID_WORD_STEP;
                  state     <= S_DEC;
               end
            end
            S_DEC: begin
               target   <= rel_tgt;
               opnd_dst <= !has_src;
               cur_mode <= has_src ? src_mode : dst_mode;
               cur_reg  <= has_src ? source_reg_field : dest_reg_field;
               if (has_src || has_dst)
                  state <= S_OPND;
               else
                  finish_op(16'h0000);
            end
            S_OPND: begin
               case (cur_mode)
                  `WID_MODE_DIRECT: finish_op(reg_addr);
                  `WID_MODE_SYMBOL: state <= S_EXTRD;
                  default:          state <= S_REGRD;
               endcase
            end
            S_REGRD: begin
               if (mem_req_o && mem_ack_i) begin
                  mem_req_o <= 1'b0;
                  hold      <= mem_rdata_i;
                  if (cur_mode == `WID_MODE_AUTOINC)
                     state <= S_INCWR;
                  else
                     finish_op(mem_rdata_i);
               end
            end
            S_INCWR: begin
               if (mem_req_o && mem_ack_i) begin
                  mem_req_o <= 1'b0;
                  finish_op(hold);
               end
            end
            S_EXTRD: begin
               if (mem_req_o && mem_ack_i) begin
                  mem_req_o <= 1'b0;
                  pc        <= pc + `WID_WORD_STEP;
                  ext       <= mem_rdata_i;
                  if (cur_reg == 4'h0)
                     finish_op(mem_rdata_i);
                  else
                     state <= S_IDXRD;
               end
            end
            S_IDXRD: begin
               if (mem_req_o && mem_ack_i) begin
                  mem_req_o <= 1'b0;
                  finish_op(ext + mem_rdata_i);
               end
            end
            S_IMMRD: begin
               if (mem_req_o && mem_ack_i) begin
                  mem_req_o <= 1'b0;
                  pc        <= pc + `WID_WORD_STEP;
                  imm       <= mem_rdata_i;
                  done_flag <= 1'b1;
                  state     <= S_IDLE;
               end
            end
            S_DATRD: begin
               if (mem_req_o && mem_ack_i) begin
                  mem_req_o <= 1'b0;
                  // An odd address picks the low byte; register words pick the high byte.
                  flag_word[`WID_FLAG_ODD_PARITY] <= src_ea[0] ? ^mem_rdata_i[7:0]
                                                               : ^mem_rdata_i[15:8];
                  done_flag <= 1'b1;
                  state     <= S_IDLE;
               end
            end
            default: state <= S_IDLE;
         endcase
      end
   end

endmodule

// ===== common/wid_defs.vh
// Constants for the workspace instruction decoder: register offsets, control bits,
// flag word bit positions, addressing-mode codes and reset values.
// Assumes it is included by name from the design file only.
`ifndef WID_DEFS_VH
`define WID_DEFS_VH

// ********************************************************************
// Register byte offsets on the AHB-Lite slave.
// ********************************************************************
`define WID_OFS_CTRL      8'h00
`define WID_OFS_WSP       8'h04
`define WID_OFS_PC        8'h08
`define WID_OFS_FLAG      8'h0c
`define WID_OFS_INSTR     8'h10
`define WID_OFS_FORMAT    8'h14
`define WID_OFS_FIELDS    8'h18
`define WID_OFS_SRC_EA    8'h1c
`define WID_OFS_DST_EA    8'h20
`define WID_OFS_TARGET    8'h24
`define WID_OFS_IMM       8'h28
`define WID_OFS_SV_WSP    8'h2c
`define WID_OFS_SV_PC     8'h30
`define WID_OFS_SV_FLAG   8'h34

// ********************************************************************
// Control register bits.
// ********************************************************************
`define WID_CTRL_START    0
`define WID_CTRL_SAVE     1
`define WID_CTRL_RESTORE  2
`define WID_STAT_BUSY     0
`define WID_STAT_DONE     1

// ********************************************************************
// Flag word bit positions (bit 15 is the leftmost flag).
// ********************************************************************
`define WID_FLAG_ODD_PARITY  10
`define WID_FLAG_EXT_OP      9

// ********************************************************************
// Addressing-mode codes and operation codes.
// ********************************************************************
`define WID_MODE_DIRECT   2'h0
`define WID_MODE_INDIR    2'h1
`define WID_MODE_SYMBOL   2'h2
`define WID_MODE_AUTOINC  2'h3
`define WID_OP_MOVE       3'h6

// ********************************************************************
// Steps, limits and reset values.
// ********************************************************************
`define WID_WORD_STEP     16'h0002
`define WID_BYTE_STEP     16'h0001
`define WID_SERIAL_MAX    4'h8
`define WID_WSP_RESET     16'h0000
`define WID_PC_RESET      16'h0000
`define WID_FLAG_RESET    16'h0000

`endif

// ===== verif/wid_mem_model.sv
// Memory on the far side of the decoder's memory port.
// Assumes the decoder's clock; each request is answered after zero to three wait cycles.
`timescale 1ns/1ps
module wid_mem_model (
   input  logic        mclk_i,
   input  logic        mem_req_i,
   input  logic        mem_we_i,
   input  logic [15:0] mem_addr_i,
   input  logic [15:0] mem_wdata_i,
   output logic [15:0] mem_rdata_o = 16'h0000,
   output logic        mem_ack_o = 1'b0
);
   logic [15:0] mem [0:32767];
   int          wait_n = 0;
   int          seed = 77;
   initial foreach (mem[i]) mem[i] = 16'h0000;
   // Read data toggles when not delivering, so a sample two cycles late sees an inverted word.
   always @(posedge mclk_i) begin
      mem_ack_o <= 1'b0;
      if (!mem_ack_o)
         mem_rdata_o <= ~mem_rdata_o;
      if (mem_req_i && !mem_ack_o) begin
         if (wait_n == 0) begin
            mem_ack_o <= 1'b1;
            wait_n <= $random(seed) & 3;
            if (mem_we_i)
               mem[mem_addr_i[15:1]] <= mem_wdata_i;
            else
               mem_rdata_o <= mem[mem_addr_i[15:1]];
         end else
            wait_n <= wait_n - 1;
      end
   end
endmodule

// ===== verif/wid_decoder_assertions.sv
// Timing checks on the decoder's bus slave and memory port.
// Assumes hready_i is tied to hreadyout_o and a single clock domain.
`timescale 1ns/1ps
module wid_decoder_assertions (
   input logic        mclk_i,
   input logic        rst_i,
   input logic        hsel_i,
   input logic [1:0]  htrans_i,
   input logic        hwrite_i,
   input logic        hready_i,
   input logic [31:0] hrdata_o,
   input logic        hreadyout_o,
   input logic        mem_req_o,
   input logic        mem_we_o,
   input logic [15:0] mem_addr_o,
   input logic [15:0] mem_wdata_o,
   input logic        mem_ack_i
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   wire take = hsel_i & htrans_i[1] & hready_i;
   wire rd_take = take & ~hwrite_i;
   sequence s_one_wait;
      !hreadyout_o ##1 hreadyout_o;
   endsequence
   sequence s_held;
      mem_req_o && !mem_ack_i;
   endsequence
   sequence s_req_same;
      mem_req_o && $stable(mem_addr_o) && $stable(mem_we_o) && $stable(mem_wdata_o);
   endsequence
   a_read_one_wait: assert property (rd_take |=> s_one_wait)
      else $error("read wait state wrong");
   a_write_no_wait: assert property (take && hwrite_i |=> hreadyout_o)
      else $error("write stalled");
   a_wait_has_cause: assert property ($fell(hreadyout_o) |-> $past(rd_take))
      else $error("wait state without read");
   a_rdata_holds: assert property (!$past(rst_i) && !$past(rd_take, 2) |-> $stable(hrdata_o))
      else $error("read data changed without read");
   a_req_stable: assert property (s_held |=> s_req_same)
      else $error("memory request changed before ack");
   a_req_release: assert property (mem_req_o && mem_ack_i |=> !mem_req_o)
      else $error("request not dropped after ack");
   a_drop_on_ack: assert property ($fell(mem_req_o) |-> $past(mem_ack_i))
      else $error("request dropped without ack");
   a_addr_even: assert property (mem_req_o |-> !mem_addr_o[0])
      else $error("odd memory address");
endmodule
bind wid_decoder wid_decoder_assertions wid_decoder_assertions_inst (.mclk_i, .rst_i, .hsel_i, .htrans_i,
   .hwrite_i, .hready_i, .hrdata_o, .hreadyout_o, .mem_req_o, .mem_we_o, .mem_addr_o, .mem_wdata_o,
   .mem_ack_i);

// ===== verif/wid_decoder_tb.sv
// Self-checking bench for the workspace instruction decoder.
// Assumes the memory model answers every request and the decoder is the only bus slave.
`timescale 1ns/1ps
module wid_decoder_tb;
   logic        mclk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        hsel_i = 1'b0;
   logic [7:0]  haddr_i = 8'h00;
   logic [1:0]  htrans_i = 2'h0;
   logic        hwrite_i = 1'b0;
   logic [31:0] hwdata_i = 32'h0;
   logic [31:0] hrdata_o, r;
   logic        hreadyout_o, hresp_o, mem_req_o, mem_we_o, mem_ack_i;
   logic [15:0] mem_addr_o, mem_wdata_o, mem_rdata_i, wsp, pc, v, s, d, f;
   int          fail_count = 0, checks_done = 0, cyc = 0, seed = 4397;
   logic [15:0] iws [3] = '{16'hcd01, 16'hdd01, 16'hc501};
   logic [15:0] incs [3] = '{16'h2, 16'h1, 16'h0};
   logic [15:0] fiw [4] = '{16'h2441, 16'h0340, 16'h3841, 16'ha284};
   logic [15:0] fexp [4] = '{16'h0004, 16'h0040, 16'h0100, 16'h0001};
   wid_decoder wid_decoder_inst (.mclk_i, .rst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i(3'h2),
      .hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o, .mem_req_o, .mem_we_o,
      .mem_addr_o, .mem_wdata_o, .mem_rdata_i, .mem_ack_i);
   wid_mem_model wid_mem_model_inst (.mclk_i, .mem_req_i(mem_req_o), .mem_we_i(mem_we_o),
      .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata_i), .mem_ack_o(mem_ack_i));
   initial forever #2 mclk_i = ~mclk_i;
   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // The ceiling is over twenty times the expected run, so only a hang reaches it.
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         finish_test();
      end
   end
   function automatic logic [15:0] rnd(input logic [15:0] m);
      return 16'($random(seed)) & m;
   endfunction
   function automatic logic [15:0] jump_target(input logic [15:0] p, input logic [7:0] dp);
      return p + 16'h2 + {{7{dp[7]}}, dp, 1'b0};
   endfunction
   function automatic logic [15:0] parity_flag(input logic [15:0] fw, input logic [15:0] rv, input int c);
      return (c >= 1 && c <= 8) ? {fw[15:11], ^rv[15:8], fw[9:0]} : fw;
   endfunction
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] dat);
      @(posedge mclk_i);
      hsel_i <= 1'b1;
      haddr_i <= a;
      htrans_i <= 2'h2;
      hwrite_i <= w;
      do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
      htrans_i <= 2'h0;
      hwdata_i <= dat;
      do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
      r = hrdata_o;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
      xfer(1'b0, a, 32'h0);
      chk(r, {16'h0, e});
      chk(32'(hresp_o), 32'h0);
   endtask
   task automatic wm(input logic [15:0] a, input logic [15:0] dat);
      wid_mem_model_inst.mem[a[15:1]] = dat;
   endtask
   task automatic run(input logic [15:0] iw, input logic [15:0] w2, input logic [15:0] w3);
      wm(pc, iw);
      wm(pc + 16'h2, w2);
      wm(pc + 16'h4, w3);
      xfer(1'b1, 8'h08, 32'(pc));
      xfer(1'b1, 8'h04, 32'(wsp));
      xfer(1'b1, 8'h00, 32'h1);
      // Only the done bit or the bench timeout ends this wait, so a hang is counted as a failure.
      do
         xfer(1'b0, 8'h00, 32'h0);
      while (r[1] !== 1'b1);
   endtask
   initial begin
      repeat (8) @(posedge mclk_i);
      rst_i <= 1'b0;
      for (int a = 0; a < 64; a += 4) rd_chk(8'(a), 16'h0);
      wsp = 16'h8000 | rnd(16'h0fe0);
      pc = 16'h0100;
      for (int k = 0; k < 3; k++) begin
         v = 16'h4000 | rnd(16'h0ffe);
         wm(wsp + 16'h8, v);
         run(iws[k], 16'h0, 16'h0);
         rd_chk(8'h20, v);
         chk(32'(wid_mem_model_inst.mem[wsp[15:1] + 15'h4]), 32'(v + incs[k]));
         rd_chk(8'h1c, wsp + 16'h2);
         rd_chk(8'h14, 16'h1);
         rd_chk(8'h08, pc + 16'h2);
         xfer(1'b0, 8'h18, 32'h0);
         chk(32'({r[25], r[12:0]}), 32'({1'b1, iws[k][12:0]}));
      end
      v = rnd(16'h0ffe);
      s = 16'h2000 | rnd(16'h0ffe);
      d = 16'h3000 | rnd(16'h0ffe);
      wm(wsp + 16'h2, v);
      run(16'hc860, s, d);
      rd_chk(8'h1c, s);
      rd_chk(8'h20, d + v);
      rd_chk(8'h08, pc + 16'h6);
      for (int k = 0; k < 3; k++) begin
         d = (k == 0) ? 16'h0080 : (k == 1) ? 16'h007f : rnd(16'h00ff);
         run(16'h1300 | d, 16'h0, 16'h0);
         rd_chk(8'h24, jump_target(pc, d[7:0]));
         rd_chk(8'h14, 16'h2);
      end
      d = rnd(16'h00ff);
      run(16'h0a00 | d, 16'h0, 16'h0);
      rd_chk(8'h14, 16'h10);
      rd_chk(8'h1c, wsp + {d[3:0], 1'b0});
      xfer(1'b0, 8'h18, 32'h0);
      chk(32'(r[16:13]), 32'(d[7:4]));
      for (int k = 0; k < 4; k++) begin
         run(fiw[k], 16'h0, 16'h0);
         rd_chk(8'h14, fexp[k]);
         xfer(1'b0, 8'h18, 32'h0);
         chk(32'(r[25]), 32'h0);
      end
      d = rnd(16'h000f);
      v = rnd(16'hffff);
      run(16'h0220 | d, v, 16'h0);
      rd_chk(8'h28, v);
      rd_chk(8'h1c, wsp + {d[14:0], 1'b0});
      rd_chk(8'h14, 16'h80);
      rd_chk(8'h08, pc + 16'h4);
      // Parity flag is preset to the wrong value so a missed update shows.
      for (int c = 8; c < 10; c++) begin
         v = rnd(16'hffff);
         f = rnd(16'hfbff) | {5'h0, ~(^v[15:8]), 10'h0};
         wm(wsp + 16'h2, v);
         xfer(1'b1, 8'h0c, 32'(f));
         run(16'h3001 | 16'(c << 6), 16'h0, 16'h0);
         rd_chk(8'h0c, parity_flag(f, v, c));
      end
      f = rnd(16'hfdff);
      xfer(1'b1, 8'h0c, 32'(f));
      run(16'h2c01, 16'h0, 16'h0);
      rd_chk(8'h0c, f | 16'h0200);
      rd_chk(8'h14, 16'h100);
      wm(wsp + 16'h2, 16'h1000);
      run(16'h0481, 16'h0, 16'h0);
      rd_chk(8'h0c, f | 16'h0200);
      xfer(1'b1, 8'h08, 32'(pc));
      xfer(1'b1, 8'h00, 32'h2);
      xfer(1'b1, 8'h04, 32'h0);
      xfer(1'b1, 8'h08, 32'h0);
      xfer(1'b1, 8'h0c, 32'h0);
      xfer(1'b1, 8'h10, 32'hffff);
      xfer(1'b1, 8'h00, 32'h4);
      rd_chk(8'h04, wsp);
      rd_chk(8'h08, pc);
      rd_chk(8'h0c, f | 16'h0200);
      rd_chk(8'h10, 16'h0481);
      finish_test();
   end
endmodule
